// *** hdl/bifm_in_cond.sv ***
// input synchroniser and per-input inversion
`timescale 1ns/10ps
module bifm_in_cond #(
	parameter int W = 6
) (
	// clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_sys_rst,
	// pins and setting
	input  wire logic [W-1:0] i_pin,
	input  wire logic [W-1:0] i_inv,
	// conditioned logic state
	output logic      [W-1:0] o_logic
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;

	generate
		for (genvar g = 0; g < W; g++) begin : g_bit
			always_ff @(posedge i_clk or posedge i_sys_rst) begin
				if (i_sys_rst) begin
					s1_reg[g] <= 1'b0;
					s2_reg[g] <= 1'b0;
				end else begin
					s1_reg[g] <= i_pin[g];
					s2_reg[g] <= s1_reg[g];
				end
			end
			assign o_logic[g] = s2_reg[g] ^ i_inv[g]; // [RULE17]
		end
	endgenerate

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	property p_inv_state;
		$stable(i_inv) && !$past(i_sys_rst, 2) |-> o_logic == ($past(i_pin, 2) ^ i_inv);
	endproperty
	a_inv_state : assert property (p_inv_state) else $error("inverted state wrong"); // [RULE17]
endmodule : bifm_in_cond

// *** hdl/bifm_maint.sv ***
// maintenance condition controller with front panel idle timeout
`timescale 1ns/10ps
module bifm_maint
	import bifm_pkg::*;
#(
	parameter logic [35:0] IDLE_CYC = MAINT_IDLE_CYC
) (
	// clock and reset
	input  wire logic i_clk,
	input  wire logic i_sys_rst,
	// requests and state
	bifm_maint_if.ctrl mif
);
	bifm_mstate_t state_reg;
	bifm_mstate_t state_next;
	logic [35:0]  idle_reg;
	logic [35:0]  idle_next;
	logic         idle_done;

	assign idle_done = idle_reg == IDLE_CYC - 36'h1;
	assign idle_next = (state_reg == ST_NORMAL || mif.activity) ? 36'h0 : idle_reg + 36'h1;

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_NORMAL: if (mif.enter && !mif.leave) state_next = ST_MAINT; // [RULE1]
			ST_MAINT:  if (mif.leave || (idle_done && !mif.activity)) state_next = ST_NORMAL; // [RULE2]
		endcase
	end

	// power loss clears the condition through reset
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state_reg <= ST_NORMAL; // [RULE2]
			idle_reg  <= 36'h0;
		end else begin
			state_reg <= state_next;
			idle_reg  <= idle_next;
		end
	end

	assign mif.active = state_reg == ST_MAINT;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	property p_enter;
		state_reg == ST_NORMAL && mif.enter && !mif.leave |=> state_reg == ST_MAINT;
	endproperty
	a_enter : assert property (p_enter) else $error("maintenance not entered"); // [RULE1]
	property p_timeout;
		state_reg == ST_MAINT && idle_done && !mif.activity |=> state_reg == ST_NORMAL;
	endproperty
	a_timeout : assert property (p_timeout) else $error("idle timeout missed"); // [RULE2]
	property p_leave;
		mif.leave |=> state_reg == ST_NORMAL;
	endproperty
	a_leave : assert property (p_leave) else $error("maintenance not left"); // [RULE2]
endmodule : bifm_maint

// *** hdl/bifm_maint_if.sv ***
// maintenance request and state signals between top and controller
`timescale 1ns/10ps
interface bifm_maint_if;
	logic enter;
	logic leave;
	logic activity;
	logic active;
	modport ctrl (input enter, input leave, input activity, output active);
	modport top  (output enter, output leave, output activity, input active);
endinterface : bifm_maint_if

// *** hdl/bifm_pkg.sv ***
// constants and register map of the binary input function matrix
package bifm_pkg;
	localparam int NUM_IN    = 6;
	localparam int NUM_FUNC  = 28;
	localparam int NUM_VBLK  = 13;
	localparam int NUM_FBLK  = 6;
	localparam int NUM_AUXT  = 3;
	localparam int NUM_AUXB  = 2;
	localparam int NUM_RELAY = 7;
	localparam int AXI_AW    = 8;
	// function index map
	localparam int FN_MAINT   = 0;
	localparam int FN_RST_SIG = 1;
	localparam int FN_RST_OUT = 2;
	localparam int FN_VBLK0   = 3;
	localparam int FN_FBLK0   = 16;
	localparam int FN_AUXT0   = 22;
	localparam int FN_AUXB0   = 25;
	localparam int FN_CB      = 27;
	// register byte offsets, and word index of the first mask register
	localparam logic [AXI_AW-1:0] ADDR_CTRL   = 8'h00;
	localparam logic [AXI_AW-1:0] ADDR_CMD    = 8'h04;
	localparam logic [AXI_AW-1:0] ADDR_STATUS = 8'h08;
	localparam logic [AXI_AW-1:0] ADDR_FUNC   = 8'h0c;
	localparam logic [5:0]        MASK_IDX0   = 6'h10;
	// field positions
	localparam int CTRL_INV_LSB   = 0;
	localparam int CTRL_NOEXT_BIT = 8;
	localparam int CMD_ENTER_BIT  = 0;
	localparam int CMD_LEAVE_BIT  = 1;
	localparam int STAT_MAINT_BIT = 8;
	localparam int STAT_BLOCK_BIT = 9;
	// reset values
	localparam logic [NUM_IN-1:0] INV_RST   = 6'h00;
	localparam logic              NOEXT_RST = 1'b0;
	localparam logic [NUM_IN-1:0] MASK_RST  = 6'h00;
	// timing
	localparam longint CLK_HZ       = 40_000_000;
	localparam longint MAINT_IDLE_S = 600;
	localparam logic [35:0] MAINT_IDLE_CYC = 36'(MAINT_IDLE_S * CLK_HZ);
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	typedef enum logic [1:0] {
		ST_NORMAL = 2'b01,
		ST_MAINT  = 2'b10
	} bifm_mstate_t;
endpackage : bifm_pkg

// *** hdl/bifm_top.sv ***
// binary input function matrix with axi4-lite register access
//
// Summary of operation
// [RULE1] maintenance is entered by mapped input, port command or front panel.
// [RULE2] maintenance ends by input, command, power loss or ten minute panel idle.
// [RULE3] maintenance without external command blocks every output contact.
// [RULE4] latched-signal reset input clears latched leds, alarm and trip memory.
// [RULE5] latched-output reset input releases every latched output contact.
// [RULE6] voltage blocking input blocks its stage and holds its delay reset.
// [RULE7] residual overvoltage blocking input blocks that stage and resets its delay.
// [RULE8] each of six frequency blocking inputs blocks its stage and resets delay.
// [RULE9] each auxiliary function is energised directly by its mapped input state.
// [RULE10] auxiliary bridges four and five have no operate timer.
// [RULE11] auxiliary bridges never feed the protection trip or alarm aggregates.
// [RULE12] auxiliary bridges are plain paths to leds and outputs only.
// [RULE13] breaker closed input feeds communications and breaker diagnostics.
// [RULE14] every function has a free per-input assignment mask.
// [RULE15] six binary inputs, so each mask is six bits wide.
// [RULE16] an empty mask never drives a function; any mapped input activates it.
// [RULE17] functions use the input state after the per-input inversion.
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module bifm_top
	import bifm_pkg::*;
#(
	parameter logic [35:0] IDLE_CYC = MAINT_IDLE_CYC
) (
	// clock and reset
	input  wire logic                      i_clk,
	input  wire logic                      i_sys_rst,
	// axi4-lite write address
	input  wire logic                      i_axi_awvalid,
	output logic                           o_axi_awready,
	input  wire logic [bifm_pkg::AXI_AW-1:0] i_axi_awaddr,
	input  wire logic [2:0]                i_axi_awprot,
	// axi4-lite write data
	input  wire logic                      i_axi_wvalid,
	output logic                           o_axi_wready,
	input  wire logic [31:0]               i_axi_wdata,
	input  wire logic [3:0]                i_axi_wstrb,
	// axi4-lite write response
	output logic                           o_axi_bvalid,
	input  wire logic                      i_axi_bready,
	output logic      [1:0]                o_axi_bresp,
	// axi4-lite read address
	input  wire logic                      i_axi_arvalid,
	output logic                           o_axi_arready,
	input  wire logic [bifm_pkg::AXI_AW-1:0] i_axi_araddr,
	input  wire logic [2:0]                i_axi_arprot,
	// axi4-lite read data
	output logic                           o_axi_rvalid,
	input  wire logic                      i_axi_rready,
	output logic      [31:0]               o_axi_rdata,
	output logic      [1:0]                o_axi_rresp,
	// binary input pins
	input  wire logic [bifm_pkg::NUM_IN-1:0]    i_bin_in,
	// front panel
	input  wire logic                      i_panel_maint_on,
	input  wire logic                      i_panel_activity,
	// output contacts
	input  wire logic [bifm_pkg::NUM_RELAY-1:0] i_relay_cmd,
	output logic      [bifm_pkg::NUM_RELAY-1:0] o_relay_drive,
	// mapped functions
	output logic                           o_maint_active,
	output logic                           o_outputs_blocked,
	output logic                           o_reset_latched_sig,
	output logic                           o_reset_latched_out,
	output logic      [bifm_pkg::NUM_VBLK-1:0]  o_volt_stage_block,
	output logic      [bifm_pkg::NUM_FBLK-1:0]  o_freq_stage_block,
	output logic      [bifm_pkg::NUM_AUXT-1:0]  o_aux_timed_energize,
	output logic      [bifm_pkg::NUM_AUXB-1:0]  o_aux_bridge,
	output logic                           o_breaker_closed_status
);
	logic [NUM_IN-1:0]   inv_reg;
	logic                noext_reg;
	logic [NUM_IN-1:0]   mask_reg [NUM_FUNC];
	logic [NUM_IN-1:0]   in_logic;
	logic [NUM_FUNC-1:0] func_next;
	logic [NUM_FUNC-1:0] func_reg;
	logic                maint_in_d_reg;
	logic [NUM_RELAY-1:0] relay_reg;
	logic                blocked;
	// write path state
	logic                aw_hold_reg;
	logic                w_hold_reg;
	logic [AXI_AW-1:0]   aw_addr_reg;
	logic [31:0]         w_data_reg;
	logic [3:0]          w_strb_reg;
	logic                bvalid_reg;
	logic [1:0]          bresp_reg;
	logic                do_wr;
	logic [5:0]          wr_idx;
	logic [5:0]          wr_midx;
	logic                wr_ctrl;
	logic                wr_cmd;
	logic                wr_mask;
	logic                wr_ok;
	logic                cmd_enter;
	logic                cmd_leave;
	// read path state
	logic                rvalid_reg;
	logic [31:0]         rdata_reg;
	logic [1:0]          rresp_reg;
	logic                do_rd;
	logic [5:0]          rd_idx;
	logic [5:0]          rd_midx;
	logic                rd_mask;
	logic                rd_known;
	logic [31:0]         rd_data;

	bifm_maint_if mif ();

	bifm_in_cond #(.W(NUM_IN)) u_in_cond (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_pin     (i_bin_in),
		.i_inv     (inv_reg),
		.o_logic   (in_logic)
	);

	bifm_maint #(.IDLE_CYC(IDLE_CYC)) u_maint (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.mif       (mif)
	);

	// function matrix: or of the masked input states
	generate
		for (genvar f = 0; f < NUM_FUNC; f++) begin : g_func
			assign func_next[f] = |(mask_reg[f] & in_logic); // [RULE14] [RULE15] [RULE16] [RULE17]
		end
	endgenerate

	// maintenance sources; input level edges request entry and exit
	assign mif.enter    = cmd_enter || i_panel_maint_on || (func_reg[FN_MAINT] && !maint_in_d_reg); // [RULE1]
	assign mif.leave    = cmd_leave || (!func_reg[FN_MAINT] && maint_in_d_reg); // [RULE2]
	assign mif.activity = i_panel_activity || i_panel_maint_on; // [RULE2]
	assign blocked      = mif.active && noext_reg; // [RULE3]

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			func_reg       <= '0;
			maint_in_d_reg <= 1'b0;
			relay_reg      <= '0;
		end else begin
			func_reg       <= func_next;
			maint_in_d_reg <= func_reg[FN_MAINT];
			relay_reg      <= blocked ? '0 : i_relay_cmd; // [RULE3]
		end
	end

	assign o_relay_drive           = relay_reg;
	assign o_maint_active          = mif.active;
	assign o_outputs_blocked       = blocked;
	assign o_reset_latched_sig     = func_reg[FN_RST_SIG]; // [RULE4]
	assign o_reset_latched_out     = func_reg[FN_RST_OUT]; // [RULE5]
	// over, under, positive, negative and residual stages in that order
	assign o_volt_stage_block      = func_reg[FN_VBLK0 +: NUM_VBLK]; // [RULE6] [RULE7]
	assign o_freq_stage_block      = func_reg[FN_FBLK0 +: NUM_FBLK]; // [RULE8]
	assign o_aux_timed_energize    = func_reg[FN_AUXT0 +: NUM_AUXT]; // [RULE9]
	// bridges go to the led and output matrix only, never through timers or aggregates
	assign o_aux_bridge            = func_reg[FN_AUXB0 +: NUM_AUXB]; // [RULE10] [RULE11] [RULE12]
	assign o_breaker_closed_status = func_reg[FN_CB]; // [RULE13]

	// write address decode
	assign do_wr   = aw_hold_reg && w_hold_reg && !bvalid_reg;
	assign wr_idx  = aw_addr_reg[7:2];
	assign wr_midx = wr_idx - MASK_IDX0;
	assign wr_ctrl = aw_addr_reg == ADDR_CTRL;
	assign wr_cmd  = aw_addr_reg == ADDR_CMD;
	assign wr_mask = wr_idx >= MASK_IDX0 && wr_midx < 6'(NUM_FUNC) && aw_addr_reg[1:0] == 2'b00;
	assign wr_ok   = wr_ctrl || wr_cmd || wr_mask;
	assign cmd_enter = do_wr && wr_cmd && w_strb_reg[0] && w_data_reg[CMD_ENTER_BIT]; // [RULE1]
	assign cmd_leave = do_wr && wr_cmd && w_strb_reg[0] && w_data_reg[CMD_LEAVE_BIT]; // [RULE2]

	assign o_axi_awready = !aw_hold_reg && !bvalid_reg;
	assign o_axi_wready  = !w_hold_reg && !bvalid_reg;
	assign o_axi_bvalid  = bvalid_reg;
	assign o_axi_bresp   = bresp_reg;

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			aw_hold_reg <= 1'b0;
			w_hold_reg  <= 1'b0;
			aw_addr_reg <= '0;
			w_data_reg  <= '0;
			w_strb_reg  <= '0;
		end else begin
			if (i_axi_awvalid && o_axi_awready) begin
				aw_hold_reg <= 1'b1;
				aw_addr_reg <= i_axi_awaddr;
			end else if (do_wr) begin
				aw_hold_reg <= 1'b0;
			end
			if (i_axi_wvalid && o_axi_wready) begin
				w_hold_reg <= 1'b1;
				w_data_reg <= i_axi_wdata;
				w_strb_reg <= i_axi_wstrb;
			end else if (do_wr) begin
				w_hold_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= RESP_OKAY;
		end else if (do_wr) begin
			bvalid_reg <= 1'b1;
			bresp_reg  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (i_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	// settings registers, byte lanes honoured
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			inv_reg   <= INV_RST;
			noext_reg <= NOEXT_RST;
		end else if (do_wr && wr_ctrl) begin
			if (w_strb_reg[0]) inv_reg <= w_data_reg[CTRL_INV_LSB +: NUM_IN]; // [RULE17]
			if (w_strb_reg[1]) noext_reg <= w_data_reg[CTRL_NOEXT_BIT]; // [RULE3]
		end
	end

	generate
		for (genvar m = 0; m < NUM_FUNC; m++) begin : g_mask
			always_ff @(posedge i_clk or posedge i_sys_rst) begin
				if (i_sys_rst) begin
					mask_reg[m] <= MASK_RST; // [RULE16]
				end else if (do_wr && wr_mask && wr_midx == 6'(m) && w_strb_reg[0]) begin
					mask_reg[m] <= w_data_reg[NUM_IN-1:0]; // [RULE14]
				end
			end
		end
	endgenerate

	// read decode and data selection
	assign do_rd    = i_axi_arvalid && o_axi_arready;
	assign rd_idx   = i_axi_araddr[7:2];
	assign rd_midx  = rd_idx - MASK_IDX0;
	assign rd_mask  = rd_idx >= MASK_IDX0 && rd_midx < 6'(NUM_FUNC) && i_axi_araddr[1:0] == 2'b00;
	assign rd_known = rd_mask || i_axi_araddr == ADDR_CTRL || i_axi_araddr == ADDR_CMD
		|| i_axi_araddr == ADDR_STATUS || i_axi_araddr == ADDR_FUNC;
	assign rd_data  =
		rd_mask                      ? {26'h0, mask_reg[rd_midx[4:0]]} :
		i_axi_araddr == ADDR_CTRL    ? {23'h0, noext_reg, 2'h0, inv_reg} :
		i_axi_araddr == ADDR_STATUS  ? {22'h0, blocked, mif.active, 2'h0, in_logic} :
		i_axi_araddr == ADDR_FUNC    ? {4'h0, func_reg} : 32'h0;

	assign o_axi_arready = !rvalid_reg;
	assign o_axi_rvalid  = rvalid_reg;
	assign o_axi_rdata   = rdata_reg;
	assign o_axi_rresp   = rresp_reg;

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= '0;
			rresp_reg  <= RESP_OKAY;
		end else if (do_rd) begin
			rvalid_reg <= 1'b1;
			rdata_reg  <= rd_data;
			rresp_reg  <= rd_known ? RESP_OKAY : RESP_SLVERR;
		end else if (i_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	property p_relay_block;
		blocked |=> o_relay_drive == '0;
	endproperty
	a_relay_block : assert property (p_relay_block) else $error("contact not blocked"); // [RULE3]

	property p_relay_pass;
		!blocked |=> o_relay_drive == $past(i_relay_cmd);
	endproperty
	a_relay_pass : assert property (p_relay_pass) else $error("contact command lost");

	property p_empty_mask;
		mask_reg[FN_RST_OUT] == '0 |=> !o_reset_latched_out;
	endproperty
	a_empty_mask : assert property (p_empty_mask) else $error("empty mask drove function"); // [RULE16]

	sequence s_cb_held;
		(i_bin_in[0] && mask_reg[FN_CB] == 6'h01 && !inv_reg[0])[*4];
	endsequence
	property p_cb_path;
		s_cb_held |-> o_breaker_closed_status;
	endproperty
	a_cb_path : assert property (p_cb_path) else $error("breaker closed state missing"); // [RULE13]

	sequence s_bridge_inv;
		(!i_bin_in[1] && mask_reg[FN_AUXB0] == 6'h02 && inv_reg[1])[*4];
	endsequence
	property p_bridge_inv;
		s_bridge_inv |-> o_aux_bridge[0] && o_aux_timed_energize == '0 || mask_reg[FN_AUXT0] != '0
			|| mask_reg[FN_AUXT0+1] != '0 || mask_reg[FN_AUXT0+2] != '0;
	endproperty
	a_bridge_inv : assert property (p_bridge_inv) else $error("bridge path wrong"); // [RULE12]

	sequence s_f6_held;
		(i_bin_in[5] && mask_reg[FN_FBLK0+5] == 6'h20 && !inv_reg[5])[*4];
	endsequence
	property p_f6_block;
		s_f6_held |-> o_freq_stage_block[5];
	endproperty
	a_f6_block : assert property (p_f6_block) else $error("frequency stage not blocked"); // [RULE8]

	sequence s_resid_held;
		(i_bin_in[1] && mask_reg[FN_VBLK0+10] == 6'h02 && !inv_reg[1])[*4];
	endsequence
	property p_resid_block;
		s_resid_held |-> o_volt_stage_block[10];
	endproperty
	a_resid_block : assert property (p_resid_block) else $error("residual stage not blocked"); // [RULE7]

	sequence s_aux_one_held;
		(i_bin_in[4] && mask_reg[FN_AUXT0] == 6'h10 && !inv_reg[4])[*4];
	endsequence
	property p_aux_one_energize;
		s_aux_one_held |-> o_aux_timed_energize[0];
	endproperty
	a_aux_one_energize : assert property (p_aux_one_energize) else $error("auxiliary not energised"); // [RULE9]

	property p_cmd_enter;
		do_wr && wr_cmd && w_strb_reg[0] && w_data_reg[CMD_ENTER_BIT] && !mif.leave && !mif.active
			|=> o_maint_active;
	endproperty
	a_cmd_enter : assert property (p_cmd_enter) else $error("command entry ignored"); // [RULE1]

	property p_rd_unmapped;
		do_rd && !rd_known |=> o_axi_rvalid && o_axi_rresp == RESP_SLVERR && o_axi_rdata == 32'h0;
	endproperty
	a_rd_unmapped : assert property (p_rd_unmapped) else $error("unmapped read answered wrongly");

	property p_bresp_hold;
		o_axi_bvalid && !i_axi_bready |=> o_axi_bvalid && $stable(o_axi_bresp);
	endproperty
	a_bresp_hold : assert property (p_bresp_hold) else $error("write response dropped");
endmodule : bifm_top

// *** verif/bifm_partner.sv ***
// model of the opto inputs and of the output matrix feeding the relay commands
`timescale 1ns/10ps
module bifm_partner (
	// clock
	input  wire logic       i_clk,
	// wanted levels from the bench
	input  wire logic [5:0] i_pin_req,
	input  wire logic [6:0] i_cmd_req,
	// lines into the block
	output logic      [5:0] o_bin_in,
	output logic      [6:0] o_relay_cmd
);
	initial begin
		o_bin_in    = 6'h00;
		o_relay_cmd = 7'h00;
	end
	// the opto levels and the matrix commands settle one edge after a request
	always @(posedge i_clk) begin
		o_bin_in    <= i_pin_req;
		o_relay_cmd <= i_cmd_req;
	end
endmodule : bifm_partner

// *** verif/tb_binary_input_function_matrix.sv ***
// self-checking bench of the binary input function matrix
`timescale 1ns/10ps
module tb_binary_input_function_matrix;
	import bifm_pkg::*;
	logic        i_clk = 1'h0, i_sys_rst = 1'h1;
	logic        i_axi_awvalid = 1'h0, i_axi_wvalid = 1'h0, i_axi_bready = 1'h0;
	logic        i_axi_arvalid = 1'h0, i_axi_rready = 1'h0;
	logic [7:0]  i_axi_awaddr = 8'h00, i_axi_araddr = 8'h00;
	logic [2:0]  i_axi_awprot = 3'h0, i_axi_arprot = 3'h0;
	logic [31:0] i_axi_wdata = 32'h0;
	logic [3:0]  i_axi_wstrb = 4'hf;
	logic        i_panel_maint_on = 1'h0, i_panel_activity = 1'h0;
	logic [5:0]  pin_req = 6'h00, i_bin_in;
	logic [6:0]  cmd_req = 7'h00, i_relay_cmd, o_relay_drive;
	logic        o_axi_awready, o_axi_wready, o_axi_bvalid, o_axi_arready, o_axi_rvalid;
	logic [1:0]  o_axi_bresp, o_axi_rresp, o_aux_bridge;
	logic [31:0] o_axi_rdata, rd;
	logic        o_maint_active, o_outputs_blocked, o_reset_latched_sig, o_reset_latched_out;
	logic [12:0] o_volt_stage_block;
	logic [5:0]  o_freq_stage_block;
	logic [2:0]  o_aux_timed_energize;
	logic        o_breaker_closed_status;
	logic [1:0]  rsp;
	int          mismatches = 0, compares = 0, cyc = 0;
	wire  [26:0] fv = {o_breaker_closed_status, o_aux_bridge, o_aux_timed_energize, o_freq_stage_block,
		o_volt_stage_block, o_reset_latched_out, o_reset_latched_sig};

	bifm_partner partner (.i_clk, .i_pin_req(pin_req), .i_cmd_req(cmd_req), .o_bin_in(i_bin_in),
		.o_relay_cmd(i_relay_cmd));
	bifm_top #(.IDLE_CYC(36'h32)) dut (.i_clk, .i_sys_rst, .i_axi_awvalid, .o_axi_awready, .i_axi_awaddr,
		.i_axi_awprot, .i_axi_wvalid, .o_axi_wready, .i_axi_wdata, .i_axi_wstrb, .o_axi_bvalid, .i_axi_bready,
		.o_axi_bresp, .i_axi_arvalid, .o_axi_arready, .i_axi_araddr, .i_axi_arprot, .o_axi_rvalid, .i_axi_rready,
		.o_axi_rdata, .o_axi_rresp, .i_bin_in, .i_panel_maint_on, .i_panel_activity, .i_relay_cmd,
		.o_relay_drive, .o_maint_active, .o_outputs_blocked, .o_reset_latched_sig, .o_reset_latched_out,
		.o_volt_stage_block, .o_freq_stage_block, .o_aux_timed_energize, .o_aux_bridge,
		.o_breaker_closed_status);

	initial begin
		forever #12.5 i_clk = ~i_clk;
	end

	task automatic stop_test();
		$display("mismatches %0d compares %0d", mismatches, compares);
		if (mismatches == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : stop_test

	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			stop_test();
		end
	end

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// write one word; waits for the response, only the bench timeout ends a hang
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic done;
		done = 1'b0;
		r = 2'h3;
		@(posedge i_clk);
		i_axi_awvalid <= 1'h1;
		i_axi_awaddr  <= a;
		i_axi_wvalid  <= 1'h1;
		i_axi_wdata   <= d;
		i_axi_bready  <= 1'h1;
		while (!done) begin
			@(posedge i_clk);
			if (i_axi_awvalid && o_axi_awready) i_axi_awvalid <= 1'h0;
			if (i_axi_wvalid && o_axi_wready) i_axi_wvalid <= 1'h0;
			if (i_axi_bready && o_axi_bvalid) begin
				r = o_axi_bresp;
				i_axi_bready <= 1'h0;
				done = 1'b1;
			end
		end
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic done;
		done = 1'b0;
		r = 2'h3;
		d = 32'h0;
		@(posedge i_clk);
		i_axi_arvalid <= 1'h1;
		i_axi_araddr  <= a;
		i_axi_rready  <= 1'h1;
		while (!done) begin
			@(posedge i_clk);
			if (i_axi_arvalid && o_axi_arready) i_axi_arvalid <= 1'h0;
			if (i_axi_rready && o_axi_rvalid) begin
				d = o_axi_rdata;
				r = o_axi_rresp;
				i_axi_rready <= 1'h0;
				done = 1'b1;
			end
		end
	endtask : axi_rd

	function automatic logic [7:0] mask_addr(input int k);
		return 8'({MASK_IDX0, 2'h0}) + 8'(4 * k);
	endfunction : mask_addr

	// register reset values, read-only and unmapped places
	task automatic t_regs();
		axi_rd(ADDR_CTRL, rd, rsp);
		chk("ctrl reset", 32'h0, rd);
		axi_rd(mask_addr(27), rd, rsp);
		chk("mask reset", 32'h0, rd);
		axi_wr(ADDR_STATUS, 32'hffff_ffff, rsp);
		chk("ro write resp", 32'(RESP_SLVERR), 32'(rsp));
		axi_rd(8'hfc, rd, rsp);
		chk("unmapped read resp", 32'(RESP_SLVERR), 32'(rsp));
	endtask : t_regs

	// every function except maintenance driven by one mapped input, nothing else moves
	task automatic t_map();
		pin_req <= 6'h3f;
		repeat (6) @(posedge i_clk);
		axi_rd(ADDR_FUNC, rd, rsp);
		chk("empty masks", 32'h0, rd);
		pin_req <= 6'h00;
		for (int k = 1; k < NUM_FUNC; k++) begin
			axi_wr(mask_addr(k), 32'(6'h01 << (k % 6)), rsp);
			pin_req <= 6'h01 << (k % 6);
			repeat (6) @(posedge i_clk);
			axi_rd(ADDR_FUNC, rd, rsp);
			chk("func reg", 32'h1 << k, rd);
			chk("func pins", 32'h1 << (k - 1), 32'(fv));
			pin_req <= 6'h00;
			axi_wr(mask_addr(k), 32'h0, rsp);
		end
	endtask : t_map

	// several inputs on one function, and inverted inputs
	task automatic t_or_inv();
		axi_wr(mask_addr(FN_CB), 32'h21, rsp);
		pin_req <= 6'h20;
		repeat (6) @(posedge i_clk);
		chk("any mapped input", 32'h1, 32'(o_breaker_closed_status));
		axi_wr(mask_addr(FN_CB), 32'h01, rsp);
		axi_wr(ADDR_CTRL, 32'h01, rsp);
		pin_req <= 6'h00;
		repeat (6) @(posedge i_clk);
		chk("inverted low pin", 32'h1, 32'(o_breaker_closed_status));
		pin_req <= 6'h01;
		repeat (6) @(posedge i_clk);
		chk("inverted high pin", 32'h0, 32'(o_breaker_closed_status));
		axi_wr(ADDR_CTRL, 32'h0, rsp);
		repeat (6) @(posedge i_clk);
		chk("plain high pin", 32'h1, 32'(o_breaker_closed_status));
		axi_wr(mask_addr(FN_CB), 32'h0, rsp);
		axi_wr(mask_addr(FN_FBLK0 + 5), 32'h20, rsp);
		axi_wr(mask_addr(FN_AUXB0), 32'h02, rsp);
		axi_wr(ADDR_CTRL, 32'h02, rsp);
		pin_req <= 6'h20;
		repeat (6) @(posedge i_clk);
		chk("sixth frequency block", 32'h20, 32'(o_freq_stage_block));
		chk("inverted bridge", 32'h1, 32'(o_aux_bridge));
		axi_wr(ADDR_CTRL, 32'h0, rsp);
		axi_wr(mask_addr(FN_FBLK0 + 5), 32'h0, rsp);
		axi_wr(mask_addr(FN_AUXB0), 32'h0, rsp);
		pin_req <= 6'h00;
	endtask : t_or_inv

	// maintenance entry, exit and contact blocking
	task automatic t_maint();
		cmd_req <= 7'h55;
		axi_wr(ADDR_CTRL, 32'h100, rsp);
		@(posedge i_clk);
		i_panel_maint_on <= 1'h1;
		@(posedge i_clk);
		i_panel_maint_on <= 1'h0;
		repeat (3) @(posedge i_clk);
		chk("panel enter", 32'h3, {o_maint_active, o_outputs_blocked});
		chk("contacts blocked", 32'h0, 32'(o_relay_drive));
		axi_wr(ADDR_CMD, 32'h2, rsp);
		repeat (3) @(posedge i_clk);
		chk("command leave", 32'h55, {o_maint_active, o_relay_drive});
		axi_wr(ADDR_CMD, 32'h1, rsp);
		repeat (3) @(posedge i_clk);
		chk("command enter", 32'h1, 32'(o_maint_active));
		repeat (70) @(posedge i_clk);
		chk("idle timeout", 32'h0, 32'(o_maint_active));
		axi_wr(mask_addr(FN_MAINT), 32'h02, rsp);
		pin_req <= 6'h02;
		repeat (6) @(posedge i_clk);
		chk("input enter", 32'h1, 32'(o_maint_active));
		pin_req <= 6'h00;
		repeat (6) @(posedge i_clk);
		chk("input leave", 32'h0, 32'(o_maint_active));
		axi_wr(ADDR_CMD, 32'h1, rsp);
		@(posedge i_clk);
		i_sys_rst <= 1'h1;
		repeat (2) @(posedge i_clk);
		i_sys_rst <= 1'h0;
		repeat (3) @(posedge i_clk);
		chk("power loss leave", 32'h0, 32'(o_maint_active));
		axi_rd(ADDR_CTRL, rd, rsp);
		chk("ctrl after reset", 32'h0, rd);
	endtask : t_maint

	initial begin
		repeat (20) @(posedge i_clk);
		i_sys_rst <= 1'h0;
		@(posedge i_clk);
		t_regs();
		t_map();
		t_or_inv();
		t_maint();
		stop_test();
	end
endmodule : tb_binary_input_function_matrix
